/* File: hdl/fsi_params.svh */
/*
 Constants for the state-image and operand-type block: image word counts,
 reset values, tag codes, exponent limits and biases, and control-word bit positions.
 Assumes inclusion once per compilation unit, before fsi_pkg.
*/
`ifndef FSI_PARAMS_SVH
`define FSI_PARAMS_SVH
`define FSI_CW_RESET      16'h037f
`define FSI_SW_RESET      16'h0000
`define FSI_TW_RESET      16'hffff
`define FSI_TAG_EMPTY     2'h3
`define FSI_TAG_VALID     2'h0
`define FSI_TAG_ZERO      2'h1
`define FSI_TAG_SPECIAL   2'h2
`define FSI_ENV16_WORDS   4'h7
`define FSI_ENV32_WORDS   4'he
`define FSI_DATA_REGS     4'h8
`define FSI_VEC_WORDS     5'h11
`define FSI_EXP_MAX       15'h7fff
`define FSI_EXP_BIAS_X    15'h3fff
`define FSI_EXP_BIAS_D    15'h3c00
`define FSI_EXP_BIAS_S    15'h3f80
`define FSI_CW_DM_BIT     1
`define FSI_CW_IM_BIT     0
`endif

/* File: hdl/fsi_pkg.sv */
/*
 Types for the state-image block: operations, operand types, modes, environment, extended value, exception flags.
 Assumes fsi_params.svh is available on the include path.
*/
package fsi_pkg;
   typedef enum logic [3:0] {
      FSI_OP_NONE, FSI_OP_ENV_STORE, FSI_OP_FULL_SAVE, FSI_OP_ENV_LOAD,
      FSI_OP_FULL_RESTORE, FSI_OP_INIT, FSI_OP_EXT_SAVE, FSI_OP_EXT_RESTORE
   } fsi_op_t;
   typedef enum logic [2:0] {
      FSI_TY_SINGLE, FSI_TY_DOUBLE, FSI_TY_EXT, FSI_TY_I16, FSI_TY_I32,
      FSI_TY_I64, FSI_TY_BCD
   } fsi_type_t;
   typedef enum logic [1:0] {
      FSI_MODE_REAL, FSI_MODE_PROT, FSI_MODE_V86, FSI_MODE_SYSMGMT
   } fsi_mode_t;
   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] stat;
      logic [15:0] tag;
      logic [31:0] ip_off;
      logic [15:0] ip_sel;
      logic [31:0] op_off;
      logic [15:0] op_sel;
      logic [10:0] opcode;
   } fsi_env_t;
   typedef struct packed {
      logic        sign;
      logic [14:0] exp;
      logic [63:0] sig;
   } fsi_ext_t;
   typedef struct packed {
      logic invalid;
      logic denormal;
   } fsi_exc_t;
endpackage

/* File: hdl/fsi_convert.sv */
/*
 Operand converter: memory operand to 80-bit extended, integer store of a supplied
 value (indefinite on masked invalid), and extended-operand classification.
 Assumes operands arrive already assembled little-endian, low byte first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsi_params.svh"
module fsi_convert
   import fsi_pkg::*;
(
   input  wire logic      ref_clk,
   input  wire logic      rst_b,
   input  wire logic      cv_load,
   input  wire fsi_type_t cv_type,
   input  wire logic [79:0] cv_mem,
   input  wire logic [15:0] cv_ctrl,
   input  wire logic      cv_store_int,
   input  wire logic      cv_store_inv,
   input  wire logic [63:0] cv_int_val,
   output logic [79:0]    cv_ext_r,
   output logic [63:0]    cv_int_r,
   output fsi_exc_t       cv_exc_r,
   output logic           cv_done_r
);
   fsi_ext_t x_nxt;
   fsi_exc_t e_nxt;
   logic [63:0] mag;
   logic [6:0]  lz;

   // Leading zero count on a 64-bit field
   function automatic logic [6:0] lzc(input logic [63:0] v);
      logic [6:0] n;
      n = 7'h40;
      for (int i = 0; i < 64; i++) begin
         if (v[i]) n = 7'(63 - i);
      end
      return n;
   endfunction

   // Integer to extended; 100..00 decodes as the most negative value
   function automatic fsi_ext_t int2x(input logic [63:0] v);
      fsi_ext_t r;
      logic [63:0] m;
      logic [6:0]  z;
      m = v[63] ? (~v + 64'h1) : v;
      z = lzc(m);
      r.sign = v[63];
      r.exp  = (m == 64'h0) ? 15'h0 : 15'(`FSI_EXP_BIAS_X + 15'd63 - 15'(z));
      r.sig  = (m == 64'h0) ? 64'h0 : (m << z);
      return r;
   endfunction

   // Conversion to extended format for every memory type
   always_comb begin
      x_nxt = '0;
      e_nxt = '0;
      mag   = '0;
      lz    = '0;
      case (cv_type)
         FSI_TY_SINGLE: begin
            x_nxt.sign = cv_mem[31];
            if (cv_mem[30:23] == 8'hff) begin
               x_nxt.exp = `FSI_EXP_MAX;
               x_nxt.sig = {1'b1, cv_mem[22:0], 40'h0};
            end else if (cv_mem[30:23] == 8'h0) begin
               mag = {1'b0, cv_mem[22:0], 40'h0};
               lz  = lzc(mag);
               if (mag != 64'h0) begin
                  e_nxt.denormal = 1'b1;
                  x_nxt.exp = 15'(`FSI_EXP_BIAS_S + 15'd1 - 15'(lz));
                  x_nxt.sig = mag << lz;
               end
            end else begin
               x_nxt.exp = 15'(`FSI_EXP_BIAS_S + 15'(cv_mem[30:23]));
               x_nxt.sig = {1'b1, cv_mem[22:0], 40'h0};
            end
         end
         FSI_TY_DOUBLE: begin
            x_nxt.sign = cv_mem[63];
            if (cv_mem[62:52] == 11'h7ff) begin
               x_nxt.exp = `FSI_EXP_MAX;
               x_nxt.sig = {1'b1, cv_mem[51:0], 11'h0};
            end else if (cv_mem[62:52] == 11'h0) begin
               mag = {1'b0, cv_mem[51:0], 11'h0};
               lz  = lzc(mag);
               if (mag != 64'h0) begin
                  e_nxt.denormal = 1'b1;
                  x_nxt.exp = 15'(`FSI_EXP_BIAS_D + 15'd1 - 15'(lz));
                  x_nxt.sig = mag << lz;
               end
            end else begin
               x_nxt.exp = 15'(`FSI_EXP_BIAS_D + 15'(cv_mem[62:52]));
               x_nxt.sig = {1'b1, cv_mem[51:0], 11'h0};
            end
         end
         FSI_TY_EXT: begin
            x_nxt = cv_mem;
            if (cv_mem[78:64] != 15'h0 && !cv_mem[63]) e_nxt.invalid = 1'b1;
            if (cv_mem[78:64] == 15'h0 && cv_mem[63]) e_nxt.denormal = 1'b1;
         end
         FSI_TY_I16: x_nxt = int2x({{48{cv_mem[15]}}, cv_mem[15:0]});
         FSI_TY_I32: x_nxt = int2x({{32{cv_mem[31]}}, cv_mem[31:0]});
         FSI_TY_I64: x_nxt = int2x(cv_mem[63:0]);
         FSI_TY_BCD: begin
            // Decimal digits weighed in a loop; 18 digits fit in 64 bits
            for (int d = 17; d >= 0; d--) begin
               mag = 64'(mag * 64'd10) + 64'(cv_mem[d*4 +: 4]);
            end
            x_nxt = int2x(cv_mem[79] ? (~mag + 64'h1) : mag);
         end
         default: x_nxt = '0;
      endcase
   end

   // Result register; the denormal flag is recorded whatever the denormal mask says
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cv_ext_r  <= '0;
         cv_exc_r  <= '0;
         cv_done_r <= 1'b0;
      end else begin
         cv_done_r <= cv_load | cv_store_int;
         if (cv_load) begin
            cv_ext_r <= x_nxt;
            cv_exc_r <= e_nxt;
         end
      end
   end

   // Integer store with masked invalid writes the indefinite pattern
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cv_int_r <= '0;
      end else if (cv_store_int) begin
         if (cv_store_inv && cv_ctrl[`FSI_CW_IM_BIT]) begin
            cv_int_r <= 64'h8000000000000000;
         end else begin
            cv_int_r <= cv_int_val;
         end
      end
   end

   chk_ext_invalid: assert property (@(posedge ref_clk) disable iff (!rst_b)
      cv_load && cv_type == FSI_TY_EXT && cv_mem[78:64] != 15'h0 && !cv_mem[63]
      |=> cv_exc_r.invalid) else $error("unsupported encoding not invalid");
   chk_pseudo_den: assert property (@(posedge ref_clk) disable iff (!rst_b)
      cv_load && cv_type == FSI_TY_EXT && cv_mem[78:64] == 15'h0 && cv_mem[63]
      |=> cv_exc_r.denormal && !cv_exc_r.invalid) else $error("pseudo denormal");
   chk_int_indef: assert property (@(posedge ref_clk) disable iff (!rst_b)
      cv_store_int && cv_store_inv && cv_ctrl[`FSI_CW_IM_BIT]
      |=> cv_int_r == 64'h8000000000000000) else $error("no indefinite");
   chk_int_minneg: assert property (@(posedge ref_clk) disable iff (!rst_b)
      cv_load && cv_type == FSI_TY_I16 && cv_mem[15:0] == 16'h8000
      |=> cv_ext_r[79] && cv_ext_r[78:64] == 15'h400e) else $error("min neg");
   chk_norm_single: assert property (@(posedge ref_clk) disable iff (!rst_b)
      cv_load && cv_type == FSI_TY_SINGLE && cv_mem[30:23] == 8'h0 && cv_mem[22:0] != 23'h0
      |=> cv_ext_r[63] && cv_exc_r.denormal) else $error("not normalized");
   cov_ext_load: cover property (@(posedge ref_clk) cv_load && cv_type == FSI_TY_EXT);
endmodule
`default_nettype wire

/* File: hdl/fsi_state_image.sv */
/*
 State-image engine: environment store/load, full save/restore, extended
 save/restore, init, and the tag-word handling, as a 16-bit word stream.
 Assumes the core presents one image word per mem_ready and packs bytes
 little-endian from the starting address it issued.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsi_params.svh"
module fsi_state_image
   import fsi_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic        op_valid,
   input  wire fsi_op_t     op_code,
   input  wire fsi_mode_t   op_mode,
   input  wire logic        op_size32,
   input  wire logic [31:0] op_base,
   output logic             op_busy,
   output logic             mem_req_r,
   output logic             mem_we_r,
   output logic [31:0]      mem_addr_r,
   output logic [15:0]      mem_wdata_r,
   input  wire logic [15:0] mem_rdata,
   input  wire logic        mem_ready,
   input  wire logic        cv_load,
   input  wire fsi_type_t   cv_type,
   input  wire logic [79:0] cv_mem,
   input  wire logic        cv_store_int,
   input  wire logic        cv_store_inv,
   input  wire logic [63:0] cv_int_val,
   output logic [79:0]      cv_ext,
   output logic [63:0]      cv_int,
   output fsi_exc_t         cv_exc,
   output logic             cv_done,
   output fsi_env_t         env_r,
   output logic [31:0]      vcsr_r
);
   typedef enum {S_IDLE, S_ENV, S_DATA, S_VEC, S_INIT} fsi_st_t;
   fsi_st_t st_r;
   fsi_op_t opc_r;
   logic        store_r;
   logic        real_r;
   logic        w32_r;
   logic [7:0]  idx_r;
   logic [79:0] data_r [8];
   logic [15:0] vec_r [`FSI_VEC_WORDS];
   logic [3:0]  env_words;
   logic        beat;
   logic [3:0]  ridx;
   logic [2:0]  rsub;

   // Image word from the environment, by layout
   function automatic logic [15:0] env_word(input fsi_env_t e, input logic [3:0] i,
                                            input logic w32, input logic rl);
      logic [15:0] w;
      w = 16'h0;
      if (!w32) begin
         case (i)
            4'h0: w = e.ctrl;
            4'h1: w = e.stat;
            4'h2: w = e.tag;
            4'h3: w = rl ? e.ip_off[15:0] : e.ip_off[15:0];
            4'h4: w = rl ? {e.ip_off[19:16], 1'b0, e.opcode} : e.ip_sel;
            4'h5: w = e.op_off[15:0];
            4'h6: w = rl ? {e.op_off[19:16], 12'h0} : e.op_sel;
            default: w = 16'h0;
         endcase
      end else begin
         case (i)
            4'h0: w = e.ctrl;
            4'h2: w = e.stat;
            4'h4: w = e.tag;
            4'h6: w = e.ip_off[15:0];
            4'h7: w = rl ? 16'h0 : e.ip_off[31:16];
            4'h8: w = rl ? {e.ip_off[31:16]} : e.ip_sel;
            4'h9: w = rl ? 16'h0 : {5'h0, e.opcode};
            4'ha: w = e.op_off[15:0];
            4'hb: w = rl ? 16'h0 : e.op_off[31:16];
            4'hc: w = rl ? e.op_off[31:16] : e.op_sel;
            default: w = 16'h0;
         endcase
      end
      return w;
   endfunction

   // Tag recomputed from contents for a non-empty register
   function automatic logic [1:0] tag_of(input logic [79:0] v);
      logic [1:0] t;
      if (v[78:64] == 15'h0 && v[63:0] == 64'h0) t = `FSI_TAG_ZERO;
      else if (v[78:64] == 15'h0 || v[78:64] == `FSI_EXP_MAX || !v[63]) t = `FSI_TAG_SPECIAL;
      else t = `FSI_TAG_VALID;
      return t;
   endfunction

   fsi_convert u_conv (
      .ref_clk      (ref_clk),
      .rst_b        (rst_b),
      .cv_load      (cv_load),
      .cv_type      (cv_type),
      .cv_mem       (cv_mem),
      .cv_ctrl      (env_r.ctrl),
      .cv_store_int (cv_store_int),
      .cv_store_inv (cv_store_inv),
      .cv_int_val   (cv_int_val),
      .cv_ext_r     (cv_ext),
      .cv_int_r     (cv_int),
      .cv_exc_r     (cv_exc),
      .cv_done_r    (cv_done)
   );

   assign env_words = w32_r ? `FSI_ENV32_WORDS : `FSI_ENV16_WORDS;
   assign beat      = mem_req_r & mem_ready;
   assign ridx      = 4'(idx_r / 8'd5);
   assign rsub      = 3'(idx_r % 8'd5);
   assign op_busy   = (st_r != S_IDLE);

   // Sequencer across image sections
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r    <= S_IDLE;
         opc_r   <= FSI_OP_NONE;
         store_r <= 1'b0;
         real_r  <= 1'b0;
         w32_r   <= 1'b0;
         idx_r   <= '0;
      end else begin
         case (st_r)
            S_IDLE: if (op_valid) begin
               opc_r   <= op_code;
               store_r <= op_code inside {FSI_OP_ENV_STORE, FSI_OP_FULL_SAVE, FSI_OP_EXT_SAVE};
               // Virtual-8086 and system management fall back to real layout
               real_r  <= (op_mode != FSI_MODE_PROT);
               w32_r   <= op_size32 | (op_code inside {FSI_OP_EXT_SAVE, FSI_OP_EXT_RESTORE});
               idx_r   <= '0;
               st_r    <= (op_code == FSI_OP_INIT) ? S_INIT :
                          (op_code == FSI_OP_NONE) ? S_IDLE : S_ENV;
            end
            S_ENV: if (beat && idx_r[3:0] == env_words - 4'h1) begin
               idx_r <= '0;
               case (opc_r)
                  FSI_OP_FULL_SAVE, FSI_OP_FULL_RESTORE,
                  FSI_OP_EXT_SAVE, FSI_OP_EXT_RESTORE: st_r <= S_DATA;
                  default: st_r <= S_IDLE;
               endcase
            end else if (beat) begin
               idx_r <= idx_r + 8'h1;
            end
            S_DATA: if (beat && idx_r == 8'd39) begin
               idx_r <= '0;
               st_r  <= (opc_r inside {FSI_OP_EXT_SAVE, FSI_OP_EXT_RESTORE}) ? S_VEC :
                        (opc_r == FSI_OP_FULL_SAVE) ? S_INIT : S_IDLE;
            end else if (beat) begin
               idx_r <= idx_r + 8'h1;
            end
            S_VEC: if (beat && idx_r == 8'(`FSI_VEC_WORDS - 5'h1)) begin
               st_r <= S_IDLE;
            end else if (beat) begin
               idx_r <= idx_r + 8'h1;
            end
            S_INIT: st_r <= S_IDLE;
            default: st_r <= S_IDLE;
         endcase
      end
   end

   // Memory request: one address per word, derived from the base and the word index
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_req_r   <= 1'b0;
         mem_we_r    <= 1'b0;
         mem_addr_r  <= '0;
         mem_wdata_r <= '0;
      end else begin
         // Drop for one cycle after each accepted word: the address register only
         // catches up then, and a held request would ask for the finished word again
         mem_req_r <= (st_r inside {S_ENV, S_DATA, S_VEC}) && !beat;
         mem_we_r <= store_r;
         // Little-endian: word k of the image sits at base plus 2k
         case (st_r)
            S_DATA: mem_addr_r <= op_base + 32'({env_words, 1'b0}) + 32'({idx_r, 1'b0});
            S_VEC:  mem_addr_r <= op_base + 32'({env_words, 1'b0}) + 32'd80 + 32'({idx_r, 1'b0});
            default: mem_addr_r <= op_base + 32'({idx_r, 1'b0});
         endcase
         case (st_r)
            S_DATA:  mem_wdata_r <= data_r[ridx[2:0]][rsub*16 +: 16];
            S_VEC:   mem_wdata_r <= vec_r[idx_r[4:0]];
            default: mem_wdata_r <= env_word(env_r, idx_r[3:0], w32_r, real_r);
         endcase
      end
   end

   // Environment registers; init after a full save resets them
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         env_r <= '{ctrl: `FSI_CW_RESET, stat: `FSI_SW_RESET, tag: `FSI_TW_RESET,
                    default: '0};
      end else if (st_r == S_INIT) begin
         env_r <= '{ctrl: `FSI_CW_RESET, stat: `FSI_SW_RESET, tag: `FSI_TW_RESET,
                    default: '0};
      end else if (beat && !store_r && st_r == S_ENV) begin
         case (idx_r[3:0])
            4'h0: env_r.ctrl <= mem_rdata;
            4'h1: if (!w32_r) env_r.stat <= mem_rdata;
            4'h2: if (!w32_r) env_r.tag <= mem_rdata; else env_r.stat <= mem_rdata;
            4'h3: if (!w32_r) env_r.ip_off[15:0] <= mem_rdata;
            4'h4: if (!w32_r) env_r.ip_sel <= mem_rdata; else env_r.tag <= mem_rdata;
            4'h5: if (!w32_r) env_r.op_off[15:0] <= mem_rdata;
            4'h6: if (!w32_r) env_r.op_sel <= mem_rdata; else env_r.ip_off[15:0] <= mem_rdata;
            4'h7: env_r.ip_off[31:16] <= mem_rdata;
            4'h8: env_r.ip_sel <= mem_rdata;
            4'h9: env_r.opcode <= mem_rdata[10:0];
            4'ha: env_r.op_off[15:0] <= mem_rdata;
            4'hb: env_r.op_off[31:16] <= mem_rdata;
            4'hc: env_r.op_sel <= mem_rdata;
            default: env_r.ctrl <= env_r.ctrl;
         endcase
      end else if (st_r == S_IDLE && op_valid && op_code == FSI_OP_ENV_LOAD) begin
         env_r.tag <= env_r.tag;
      end else if (!op_busy && opc_r inside {FSI_OP_ENV_LOAD, FSI_OP_FULL_RESTORE}) begin
         // Tags from environment load or full restore only say empty or not; contents decide the rest
         for (int r = 0; r < 8; r++) begin
            if (env_r.tag[r*2 +: 2] != `FSI_TAG_EMPTY)
               env_r.tag[r*2 +: 2] <= tag_of(data_r[r]);
         end
      end
   end

   // Data registers; only full or extended restore writes them
   always_ff @(posedge ref_clk) begin
      if (beat && !store_r && st_r == S_DATA) begin
         data_r[ridx[2:0]][rsub*16 +: 16] <= mem_rdata;
      end
   end

   // Vector state carried by the extended forms
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         vcsr_r <= '0;
      end else if (beat && !store_r && st_r == S_VEC) begin
         if (idx_r == 8'h0) vcsr_r[15:0] <= mem_rdata;
         if (idx_r == 8'h1) vcsr_r[31:16] <= mem_rdata;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (beat && !store_r && st_r == S_VEC) vec_r[idx_r[4:0]] <= mem_rdata;
   end

   chk_env_no_data: assert property (@(posedge ref_clk) disable iff (!rst_b)
      st_r == S_ENV && beat && idx_r[3:0] == env_words - 4'h1 && opc_r == FSI_OP_ENV_STORE
      |=> st_r == S_IDLE) else $error("env store touched data");
   chk_save_data: assert property (@(posedge ref_clk) disable iff (!rst_b)
      st_r == S_ENV && beat && idx_r[3:0] == env_words - 4'h1 && opc_r == FSI_OP_FULL_SAVE
      |=> st_r == S_DATA) else $error("full save skipped data");
   chk_save_init: assert property (@(posedge ref_clk) disable iff (!rst_b)
      st_r == S_INIT |=> env_r.tag == `FSI_TW_RESET) else $error("tags not empty");
   chk_real_layout: assert property (@(posedge ref_clk) disable iff (!rst_b)
      st_r == S_IDLE && op_valid && op_code != FSI_OP_NONE &&
      op_mode inside {FSI_MODE_V86, FSI_MODE_SYSMGMT}
      |=> real_r) else $error("fallback mode used protected layout");
   chk_ord16: assert property (@(posedge ref_clk) disable iff (!rst_b)
      st_r == S_ENV && store_r && !w32_r && idx_r == 8'h0 |=> mem_wdata_r == env_r.ctrl)
      else $error("16-bit image order");
   // A waiting request keeps its address and data until the word is taken
   chk_req_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
      mem_req_r && !mem_ready |=> mem_req_r && $stable(mem_addr_r) && $stable(mem_wdata_r))
      else $error("request changed while waiting");
   cov_full_save: cover property (@(posedge ref_clk) st_r == S_DATA ##1 st_r == S_INIT);
   cov_env_load: cover property (@(posedge ref_clk) opc_r == FSI_OP_ENV_LOAD && st_r == S_ENV);
   cov_ext: cover property (@(posedge ref_clk) st_r == S_VEC);
endmodule
`default_nettype wire

/* File: bench/fsi_mem_model.sv */
/*
 Core-side memory model: a 16-bit word store answering each held request
 with a one-cycle ready pulse after a chosen wait.
 Assumes one request at a time, held with its address until ready.
*/
`timescale 1ns/1ps
`default_nettype none
module fsi_mem_model (
   input  wire logic        ref_clk,
   input  wire logic [3:0]  lat,
   input  wire logic        mem_req_r,
   input  wire logic        mem_we_r,
   input  wire logic [31:0] mem_addr_r,
   input  wire logic [15:0] mem_wdata_r,
   output logic [15:0]      mem_rdata = 16'h0000,
   output logic             mem_ready = 1'b0
);
   logic [15:0] mem [0:1023];
   logic [3:0]  wait_c = 4'h0;
   // Word k of an image lives at base+2k; outside a ready cycle the read bus inverts itself every cycle
   always @(posedge ref_clk) begin
      mem_rdata <= ~mem_rdata;
      if (mem_ready) begin
         mem_ready <= 1'b0;
         if (mem_we_r) mem[mem_addr_r[10:1]] <= mem_wdata_r;
      end else if (mem_req_r && wait_c >= lat) begin
         mem_ready <= 1'b1;
         wait_c <= 4'h0;
         mem_rdata <= mem[mem_addr_r[10:1]];
      end else if (mem_req_r) begin
         wait_c <= wait_c + 4'h1;
      end
   end
endmodule
`default_nettype wire

/* File: bench/fsi_state_image_test.sv */
/*
 Self-checking bench for the state-image engine and its converter.
 Assumes the memory model answers the engine's word stream.
*/
`timescale 1ns/1ps
`default_nettype none
module fsi_state_image_test;
   import fsi_pkg::*;
   logic ref_clk = 1'b0, rst_b = 1'b0, op_valid = 1'b0, op_size32 = 1'b0, op_busy;
   fsi_op_t op_code = FSI_OP_NONE;
   fsi_mode_t op_mode = FSI_MODE_PROT;
   logic [31:0] op_base = 32'h0, mem_addr_r, vcsr_r;
   logic mem_req_r, mem_we_r, mem_ready, cv_load = 1'b0, cv_store_int = 1'b0;
   logic cv_store_inv = 1'b0, cv_done;
   logic [15:0] mem_wdata_r, mem_rdata;
   logic [3:0] lat = 4'h0;
   fsi_type_t cv_type = FSI_TY_SINGLE;
   logic [79:0] cv_mem = 80'h0, cv_ext;
   logic [63:0] cv_int, cv_int_val = 64'h0123456789abcdef;
   fsi_exc_t cv_exc;
   fsi_env_t env_r;
   int n_errors = 0, compares = 0, n_wr = 0, w0, k;
   always #5 ref_clk = ~ref_clk;
   fsi_state_image i_fsi_state_image (.ref_clk(ref_clk), .rst_b(rst_b), .op_valid(op_valid),
      .op_code(op_code), .op_mode(op_mode), .op_size32(op_size32), .op_base(op_base),
      .op_busy(op_busy), .mem_req_r(mem_req_r), .mem_we_r(mem_we_r), .mem_addr_r(mem_addr_r),
      .mem_wdata_r(mem_wdata_r), .mem_rdata(mem_rdata), .mem_ready(mem_ready),
      .cv_load(cv_load), .cv_type(cv_type), .cv_mem(cv_mem), .cv_store_int(cv_store_int),
      .cv_store_inv(cv_store_inv), .cv_int_val(cv_int_val), .cv_ext(cv_ext), .cv_int(cv_int),
      .cv_exc(cv_exc), .cv_done(cv_done), .env_r(env_r), .vcsr_r(vcsr_r));
   fsi_mem_model i_fsi_mem_model (.ref_clk(ref_clk), .lat(lat), .mem_req_r(mem_req_r),
      .mem_we_r(mem_we_r), .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r),
      .mem_rdata(mem_rdata), .mem_ready(mem_ready));
   // Accepted writes, counted at the edge where ready is sampled
   always @(posedge ref_clk) if (mem_req_r && mem_ready && mem_we_r) n_wr <= n_wr + 1;
   task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // One image operation; busy is awaited under a bound
   task automatic run_op(input fsi_op_t c, input fsi_mode_t m, input logic s, input int b);
      int i;
      @(posedge ref_clk);
      op_valid <= 1'b1;
      op_code <= c;
      op_mode <= m;
      op_size32 <= s;
      op_base <= b;
      @(posedge ref_clk);
      op_valid <= 1'b0;
      for (i = 0; i < 1000; i++) begin
         @(posedge ref_clk);
         #1;
         if (op_busy === 1'b0) break;
      end
      if (i == 1000) check("busy", 1, 0);
      repeat (2) @(posedge ref_clk);
   endtask
   // One converter request, then wait for its done pulse
   task automatic conv(input fsi_type_t t, input logic [79:0] m, input logic st);
      int i;
      @(posedge ref_clk);
      cv_type <= t;
      cv_mem <= m;
      cv_load <= ~st;
      cv_store_int <= st;
      cv_store_inv <= st;
      @(posedge ref_clk);
      cv_load <= 1'b0;
      cv_store_int <= 1'b0;
      for (i = 0; i < 4; i++) begin
         #1;
         if (cv_done === 1'b1) break;
         @(posedge ref_clk);
      end
      check("done", cv_done, 1);
   endtask
   // A hang is cut short at 10000 cycles, well past the expected run of just over a thousand cycles
   initial begin
      #100000;
      n_errors++;
      end_sim();
   end
   initial begin
      for (k = 0; k < 1024; k++) i_fsi_mem_model.mem[k] = 16'(k * 3);
      i_fsi_mem_model.mem[256] = 16'h027f;
      i_fsi_mem_model.mem[257] = 16'h0000;
      i_fsi_mem_model.mem[258] = 16'hfffc;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      #1;
      check("rst ctrl", env_r.ctrl, 16'h037f);
      check("rst tag", env_r.tag, 16'hffff);
      w0 = n_wr;
      run_op(FSI_OP_ENV_STORE, FSI_MODE_PROT, 1'b0, 32'h100);
      check("env16 words", n_wr - w0, 7);
      check("w0 ctrl", i_fsi_mem_model.mem[128], 16'h037f);
      check("w1 stat", i_fsi_mem_model.mem[129], 16'h0000);
      check("w2 tag", i_fsi_mem_model.mem[130], 16'hffff);
      lat <= 4'h3;
      w0 = n_wr;
      run_op(FSI_OP_FULL_RESTORE, FSI_MODE_PROT, 1'b0, 32'h200);
      check("rst no wr", n_wr - w0, 0);
      check("ld ctrl", env_r.ctrl, 16'h027f);
      check("ld tag", env_r.tag, 16'hfffe);
      run_op(FSI_OP_ENV_STORE, FSI_MODE_REAL, 1'b1, 32'h400);
      run_op(FSI_OP_ENV_STORE, FSI_MODE_V86, 1'b1, 32'h500);
      for (k = 0; k < 14; k++) check("v86", i_fsi_mem_model.mem[640 + k],
         i_fsi_mem_model.mem[512 + k]);
      lat <= 4'h0;
      w0 = n_wr;
      run_op(FSI_OP_FULL_SAVE, FSI_MODE_PROT, 1'b0, 32'h300);
      check("save words", n_wr - w0, 47);
      check("saved ctrl", i_fsi_mem_model.mem[384], 16'h027f);
      check("init ctrl", env_r.ctrl, 16'h037f);
      check("init tag", env_r.tag, 16'hffff);
      conv(FSI_TY_I16, 80'h8000, 1'b0);
      check("i16 min", cv_ext, {1'b1, 15'h400e, 64'h8000000000000000});
      conv(FSI_TY_SINGLE, 80'h1, 1'b0);
      check("sgl denorm", cv_ext, {1'b0, 15'h3f6a, 64'h8000000000000000});
      conv(FSI_TY_EXT, {1'b0, 15'h7fff, 64'h0}, 1'b0);
      check("pseudo inf", cv_exc.invalid, 1);
      conv(FSI_TY_EXT, {1'b1, 15'h0001, 64'h0}, 1'b0);
      check("unnormal", cv_exc.invalid, 1);
      conv(FSI_TY_EXT, {1'b0, 15'h0000, 64'h8000000000000001}, 1'b0);
      check("pseudo den", cv_exc, 2'b01);
      conv(FSI_TY_I64, 80'h0, 1'b1);
      check("int indef", cv_int, 64'h8000000000000000);
      conv(FSI_TY_BCD, {1'b1, 79'h12}, 1'b0);
      check("bcd", cv_ext, {1'b1, 15'h4002, 64'hc000000000000000});
      run_op(FSI_OP_ENV_LOAD, FSI_MODE_PROT, 1'b0, 32'h200);
      check("envld ctrl", env_r.ctrl, 16'h027f);
      check("envld tag", env_r.tag, 16'hfffe);
      run_op(FSI_OP_EXT_RESTORE, FSI_MODE_PROT, 1'b0, 32'h600);
      check("vcsr", vcsr_r, 32'h09a509a2);
      w0 = n_wr;
      run_op(FSI_OP_EXT_SAVE, FSI_MODE_PROT, 1'b0, 32'h700);
      check("ext words", n_wr - w0, 71);
      conv(FSI_TY_I64, 80'h0, 1'b1);
      check("int unmasked", cv_int, 64'h0123456789abcdef);
      end_sim();
   end
endmodule
`default_nettype wire
